// File: bench/flash_array_model.sv
`timescale 1ns/10ps
// Passive stand-in for the array: times the strobe and high-voltage lines it is given
module flash_array_model (
	input  wire logic       core_clk,
	input  wire logic       storageStrobe,
	input  wire logic       programPulse,
	input  wire logic       pageErasePulse,
	input  wire logic       moduleErasePulse,
	output int              tranLen,
	output int              pulseLen,
	output int              holdLen,
	output logic      [2:0] pulseKind,
	output logic            hvFault
);
	logic       active = 1'b0;
	wire  [2:0] hv     = {moduleErasePulse, pageErasePulse, programPulse};

	initial hvFault = 1'b0;

	always @(posedge core_clk) begin
		if (!storageStrobe && hv != 3'b000)
			hvFault <= 1'b1;
		if (!storageStrobe)
			active <= 1'b0;
		else if (!active) begin
			active    <= 1'b1;
			tranLen   <= 1;
			pulseLen  <= 0;
			holdLen   <= 0;
			pulseKind <= 3'b000;
		end else if (hv != 3'b000) begin
			pulseLen  <= pulseLen + 1;
			pulseKind <= pulseKind | hv;
		end else if (pulseKind != 3'b000)
			holdLen <= holdLen + 1;
		else
			tranLen <= tranLen + 1;
	end
endmodule

// File: bench/testbench.sv
`timescale 1ns/10ps
`include "flash_timing_defines.svh"
module testbench;
	logic        core_clk = 1'b0;
	logic        rst_n, clkEn, psel, penable, pwrite, powerSave, nmiIn, err;
	logic [7:0]  paddr, portOut, portOe;
	logic [31:0] pwdata, prdata, rdv, v;
	logic        pready, pslverr, nmiPending, busy, storageStrobe, slowClk;
	logic        programPulse, pageErasePulse, moduleErasePulse, hvFault, measure, seenStrobe;
	logic [2:0]  pulseKind;
	logic [31:0] seed = 32'd77;
	int          tranLen, pulseLen, holdLen, setupLen, rcvLen, bad_count, tests_run, n;
	wire  [2:0]  lv = {slowClk, busy, pready};

	always #5 core_clk = ~core_clk;

	flash_program_erase_timing flash_program_erase_timing_inst (.core_clk, .rst_n, .clkEn,
		.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .powerSave,
		.nmiIn, .nmiPending, .busy, .storageStrobe, .programPulse, .pageErasePulse,
		.moduleErasePulse, .slowClk, .portOut, .portOe);

	flash_array_model flash_array_model_inst (.core_clk, .storageStrobe, .programPulse,
		.pageErasePulse, .moduleErasePulse, .tranLen, .pulseLen, .holdLen, .pulseKind, .hvFault);

	always @(posedge core_clk) begin
		if (measure && storageStrobe === 1'b1)
			seenStrobe = 1'b1;
		else if (measure && busy === 1'b1 && !seenStrobe)
			setupLen++;
		else if (measure && busy === 1'b1)
			rcvLen++;
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic int plen(int pre, int mult, int cnt);
		return (pre + 1) * mult * (cnt + 1);
	endfunction

	task automatic tally_and_finish();
		$display("Checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wait_lvl(input int i, input logic val, input int lim);
		n = 0;
		while (lv[i] !== val && n < lim) begin
			@(posedge core_clk);
			n++;
		end
		if (lv[i] !== val) begin
			$display("Error timeout on signal %0d", i);
			bad_count++;
			tally_and_finish();
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		wait_lvl(0, 1'b1, 16);
		rdv = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic run_op(input logic [1:0] op, input logic tgt, input logic poke);
		logic [31:0] c [8];
		logic [31:0] pp, pd;
		int          pre, pc, hc;
		pp = rnd() & 1;
		pd = rnd() & 1;
		// Short pulses keep high voltage time low
		for (int i = 0; i < 8; i++)
			c[i] = (i == 3 || i == 4) ? 0 : rnd() & 3;
		apb(1'b1, `OFS_PGM_PRESCALE, pp);
		apb(1'b1, `OFS_DATA_PRESCALE, pd);
		for (int i = 0; i < 8; i++)
			apb(1'b1, 8'(`OFS_SETUP + 4 * i), c[i]);
		pre = tgt ? pd : pp;
		setupLen = 0;
		rcvLen = 0;
		seenStrobe = 1'b0;
		measure = 1'b1;
		apb(1'b1, `OFS_CTRL, {29'd0, tgt, op});
		if (poke)
			apb(1'b1, `OFS_CTRL, 32'h3);
		@(posedge core_clk);
		wait_lvl(1, 1'b0, 20000);
		measure = 1'b0;
		pc = op == 2'd1 ? c[2] : op == 2'd2 ? c[3] : c[4];
		hc = op == 2'd3 ? c[6] : c[5];
		chk("setup", plen(pre, 1, c[0]), setupLen);
		chk("transition", plen(pre, 1, c[1]), tranLen);
		chk("pulse", plen(pre, op == 2'd1 ? 8 : 4096, pc), pulseLen);
		chk("hold", plen(pre, op == 2'd3 ? 8 : 1, hc), holdLen);
		chk("recovery", plen(pre, 1, c[7]), rcvLen);
		chk("pulse kind", 32'(1 << (op - 1)), pulseKind);
		chk("hv fault", 0, hvFault);
	endtask

	initial begin
		rst_n = 1'b0;
		clkEn = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		powerSave = 1'b0;
		nmiIn = 1'b0;
		measure = 1'b0;
		seenStrobe = 1'b0;
		bad_count = 0;
		tests_run = 0;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		chk("oe after reset", 0, portOe);
		apb(1'b0, `OFS_SETUP, 32'h0);
		chk("count reset", 32'hff, rdv);
		apb(1'b0, 8'h2c, 32'h0);
		chk("unmapped error", 1, err);
		for (int k = 0; k < 6; k++)
			run_op(2'(k % 3 + 1), 1'(rnd()), k == 0);
		v = rnd();
		apb(1'b1, `OFS_PORT, {16'd0, v[15:0]});
		powerSave <= 1'b1;
		apb(1'b1, `OFS_PORT, ~v);
		chk("port out", v[7:0], portOut);
		chk("port oe", v[15:8], portOe);
		nmiIn <= 1'b1;
		@(posedge core_clk);
		nmiIn <= 1'b0;
		@(posedge core_clk);
		chk("nmi pending", 1, nmiPending);
		apb(1'b1, `OFS_STATUS, 32'h10);
		chk("nmi clear", 0, nmiPending);
		// Clock enable low must freeze even the interrupt flag
		clkEn <= 1'b0;
		nmiIn <= 1'b1;
		repeat (2) @(posedge core_clk);
		chk("nmi frozen", 0, nmiPending);
		clkEn <= 1'b1;
		nmiIn <= 1'b0;
		rst_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		chk("oe in reset", 0, portOe);
		rst_n <= 1'b1;
		powerSave <= 1'b0;
		@(posedge core_clk);
		v = rnd() & 32'h3ff;
		apb(1'b1, `OFS_SLOWDIV, v);
		wait_lvl(2, 1'b0, 3000);
		wait_lvl(2, 1'b1, 3000);
		wait_lvl(2, 1'b0, 3000);
		chk("slow half", (v < 499 ? 499 : v) + 1, n);
		tally_and_finish();
	end
endmodule

// File: src/flash_program_erase_timing.sv
// Operation
// - Setup phase lasts clk*(prescale+1)*(setup+1) before the strobe rises, at least 5 us.
// - Strobe to pulse wait lasts clk*(prescale+1)*(transition+1), at least 10 us.
// - Program pulse lasts clk*(prescale+1)*8*(program+1), between 20 and 40 us.
// - Page erase pulse lasts clk*(prescale+1)*4096*(page erase+1), at least 20 ms.
// - Module erase pulse lasts clk*(prescale+1)*4096*(module erase+1), at least 200 ms.
// - After program or page erase, strobe holds clk*(prescale+1)*(hold+1), at least 5 us.
// - After module erase, strobe holds clk*(prescale+1)*8*(module hold+1), at least 100 us.
// - Recovery after strobe release lasts clk*(prescale+1)*(recovery+1), at least 1 us.
// - During reset all port outputs are released to high impedance.
// - In power save the port pins keep their previous value and direction.
// - Reset and the nonmaskable interrupt input stay live during power save.
// - The internally divided slow clock never has a period below 10000 ns.
`timescale 1ns/10ps
`include "flash_timing_defines.svh"

module flash_program_erase_timing
	import flash_timing_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        clkEn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        powerSave,
	input  wire logic        nmiIn,
	output logic             nmiPending,
	output logic             busy,
	output logic             storageStrobe,
	output logic             programPulse,
	output logic             pageErasePulse,
	output logic             moduleErasePulse,
	output logic             slowClk,
	output logic      [7:0]  portOut,
	output logic      [7:0]  portOe
);

	logic [7:0]  pgmPrescale;
	logic [7:0]  dataPrescale;
	logic [7:0]  cntReg [`CNT_REGS];
	logic [15:0] slowDiv;
	logic [15:0] slowCnt;
	logic        targetData;
	op_t         opReg;
	phase_t      state;
	phase_t      next_state;
	logic [7:0]  preCnt;
	logic [11:0] subCnt;
	logic [7:0]  phaseCnt;
	phase_cfg_t  cfg;

	// APB decode
	wire        access   = psel && penable && !pready;
	wire        wrDone   = psel && penable && pready && pwrite;
	wire        rdAccess = access && !pwrite;
	wire [5:0]  wordIdx  = paddr[7:2];
	wire [5:0]  cntBase  = 6'(`OFS_SETUP >> 2);
	wire        inCntWin = (wordIdx >= cntBase) && (wordIdx < cntBase + 6'(`CNT_REGS));
	wire [2:0]  cntIdx   = 3'(wordIdx - cntBase);
	wire        hitPgm   = paddr == `OFS_PGM_PRESCALE;
	wire        hitData  = paddr == `OFS_DATA_PRESCALE;
	wire        hitCnt   = inCntWin && (paddr[1:0] == 2'b00);
	wire        hitCtrl  = paddr == `OFS_CTRL;
	wire        hitStat  = paddr == `OFS_STATUS;
	wire        hitPort  = paddr == `OFS_PORT;
	wire        hitSlow  = paddr == `OFS_SLOWDIV;
	wire        mapped   = hitPgm || hitData || hitCnt || hitCtrl || hitStat || hitPort || hitSlow;
	// Timing settings are locked while an operation runs so a phase length cannot move
	wire        cfgWrite = wrDone && (state == PH_IDLE);
	wire [1:0]  wrOp     = pwdata[`CTRL_OP_MSB:`CTRL_OP_LSB];
	wire        startOp  = cfgWrite && hitCtrl && (wrOp != OP_NONE);
	wire        nmiClear = wrDone && hitStat && pwdata[`STAT_NMI_BIT];

	wire [31:0] statWord = {27'h0, nmiPending, state, busy};
	wire [31:0] portWord = {16'h0, portOe, portOut};
	wire [31:0] rdWord   = hitPgm  ? {24'h0, pgmPrescale} :
	                       hitData ? {24'h0, dataPrescale} :
	                       hitCnt  ? {24'h0, cntReg[cntIdx]} :
	                       hitCtrl ? {29'h0, targetData, opReg} :
	                       hitStat ? statWord :
	                       hitPort ? portWord :
	                       hitSlow ? {16'h0, slowDiv} : 32'h0;

	// One wait state on every access; unmapped addresses answer with an error
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end else if (clkEn) begin
			pready  <= access;
			pslverr <= access && !mapped;
			prdata  <= rdAccess ? rdWord : 32'h0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			pgmPrescale  <= `RST_COUNT;
			dataPrescale <= `RST_COUNT;
			slowDiv      <= `RST_SLOWDIV;
		end else if (clkEn && cfgWrite) begin
			if (hitPgm)
				pgmPrescale <= pwdata[7:0];
			if (hitData)
				dataPrescale <= pwdata[7:0];
			if (hitSlow)
				slowDiv <= pwdata[15:0];
		end
	end

	generate
		for (genvar i = 0; i < `CNT_REGS; i++) begin : g_cnt
			always_ff @(posedge core_clk) begin
				if (!rst_n)
					cntReg[i] <= `RST_COUNT;
				else if (clkEn && cfgWrite && hitCnt && cntIdx == 3'(i))
					cntReg[i] <= pwdata[7:0];
			end
		end
	endgenerate

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			opReg      <= OP_NONE;
			targetData <= 1'b0;
		end else if (clkEn && startOp) begin
			opReg      <= op_t'(wrOp);
			targetData <= pwdata[`CTRL_TARGET_BIT];
		end
	end

	// Phase configuration follows the running phase and operation
	wire [7:0] curPre = targetData ? dataPrescale : pgmPrescale;
	wire       isMod  = opReg == OP_MERASE;
	wire [2:0] pulseIdx = (opReg == OP_PROG) ? `IDX_PROG :
	                      isMod ? `IDX_MERASE : `IDX_PERASE;
	wire [11:0] pulseMax = (opReg == OP_PROG) ? `MULT8_MAX : `MULT4096_MAX;
	wire [2:0] cfgIdx = (state == PH_TRAN)  ? `IDX_TRAN :
	                    (state == PH_PULSE) ? pulseIdx :
	                    (state == PH_HOLD)  ? (isMod ? `IDX_MHOLD : `IDX_HOLD) :
	                    (state == PH_RCV)   ? `IDX_RCV : `IDX_SETUP;
	wire [11:0] cfgMax = (state == PH_PULSE) ? pulseMax :
	                     (state == PH_HOLD && isMod) ? `MULT8_MAX : `MULT1_MAX;
	assign cfg = '{pre: curPre, multMax: cfgMax, count: cntReg[cfgIdx]};

	wire tick      = (state != PH_IDLE) && (preCnt == cfg.pre);
	wire unitDone  = tick && (subCnt == cfg.multMax);
	wire phaseDone = unitDone && (phaseCnt == cfg.count);

	// Counters cascade prescaler, multiplier and phase count
	always_ff @(posedge core_clk) begin
		if (!rst_n || (clkEn && (state == PH_IDLE || phaseDone))) begin
			preCnt   <= 8'h0;
			subCnt   <= 12'h0;
			phaseCnt <= 8'h0;
		end else if (clkEn) begin
			preCnt <= tick ? 8'h0 : preCnt + 8'h1;
			if (tick)
				subCnt <= unitDone ? 12'h0 : subCnt + 12'h1;
			if (unitDone)
				phaseCnt <= phaseCnt + 8'h1;
		end
	end

	always_comb begin
		next_state = state;
		unique case (state)
			PH_IDLE:  if (startOp) next_state = PH_SETUP;
			PH_SETUP: if (phaseDone) next_state = PH_TRAN;
			PH_TRAN:  if (phaseDone) next_state = PH_PULSE;
			PH_PULSE: if (phaseDone) next_state = PH_HOLD;
			PH_HOLD:  if (phaseDone) next_state = PH_RCV;
			PH_RCV:   if (phaseDone) next_state = PH_IDLE;
			default:  next_state = PH_IDLE;
		endcase
	end

	// Outputs are taken from the next state so they line up with the phase
	wire nxtStrobe = next_state == PH_TRAN || next_state == PH_PULSE || next_state == PH_HOLD;
	wire nxtPulse  = next_state == PH_PULSE;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state            <= PH_IDLE;
			busy             <= 1'b0;
			storageStrobe    <= 1'b0;
			programPulse     <= 1'b0;
			pageErasePulse   <= 1'b0;
			moduleErasePulse <= 1'b0;
		end else if (clkEn) begin
			state            <= next_state;
			busy             <= next_state != PH_IDLE;
			storageStrobe    <= nxtStrobe;
			programPulse     <= nxtPulse && opReg == OP_PROG;
			pageErasePulse   <= nxtPulse && opReg == OP_PERASE;
			moduleErasePulse <= nxtPulse && opReg == OP_MERASE;
		end
	end

	// Interrupt request caught whenever clkEn is high; a request input held high beats the clear
	always_ff @(posedge core_clk) begin
		if (!rst_n)
			nmiPending <= 1'b0;
		else if (clkEn)
			nmiPending <= nmiIn || (nmiPending && !nmiClear);
	end

	// Reset releases the port; power save freezes it
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			portOut <= 8'h0;
			portOe  <= 8'h0;
		end else if (clkEn && wrDone && hitPort && !powerSave) begin
			portOut <= pwdata[7:0];
			portOe  <= pwdata[`PORT_DIR_MSB:`PORT_DIR_LSB];
		end
	end

	// Half period clamped so the slow clock cannot run too fast
	wire [15:0] minHalf  = 16'(`SLOW_MIN_HALF - 1);
	wire [15:0] halfMax  = (slowDiv < minHalf) ? minHalf : slowDiv;
	wire        slowFlip = slowCnt >= halfMax;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			slowCnt <= 16'h0;
			slowClk <= 1'b0;
		end else if (clkEn) begin
			slowCnt <= slowFlip ? 16'h0 : slowCnt + 16'h1;
			if (slowFlip)
				slowClk <= !slowClk;
		end
	end

	// Helper logic for the checks below
	localparam int SlowMinHalf = `SLOW_MIN_HALF;
	logic [31:0] phaseCycles;
	logic [15:0] slowSpan;
	wire         anyPulse = programPulse || pageErasePulse || moduleErasePulse;

	function automatic logic [31:0] lenOf(logic [7:0] pre, logic [11:0] mx, logic [7:0] n);
		return (32'(pre) + 32'h1) * (32'(mx) + 32'h1) * (32'(n) + 32'h1);
	endfunction

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			phaseCycles <= 32'h0;
			slowSpan    <= 16'h0;
		end else if (clkEn) begin
			phaseCycles <= (state != next_state) ? 32'h0 : phaseCycles + 32'h1;
			slowSpan    <= $changed(slowClk) ? 16'h1 : slowSpan + 16'h1;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	sequence leave(phase_t ph);
		clkEn && state == ph && next_state != ph;
	endsequence

	sequence start_req;
		clkEn && startOp;
	endsequence

	chk_setup_len: assert property (leave(PH_SETUP) |->
		phaseCycles == lenOf(curPre, `MULT1_MAX, cntReg[`IDX_SETUP]) - 32'h1)
		else $error("setup phase length wrong");
	chk_tran_len: assert property (leave(PH_TRAN) |->
		phaseCycles == lenOf(curPre, `MULT1_MAX, cntReg[`IDX_TRAN]) - 32'h1)
		else $error("transition wait length wrong");
	chk_prog_len: assert property (leave(PH_PULSE) ##0 (opReg == OP_PROG) |->
		phaseCycles == lenOf(curPre, `MULT8_MAX, cntReg[`IDX_PROG]) - 32'h1)
		else $error("program pulse length wrong");
	chk_page_len: assert property (leave(PH_PULSE) ##0 (opReg == OP_PERASE) |->
		phaseCycles == lenOf(curPre, `MULT4096_MAX, cntReg[`IDX_PERASE]) - 32'h1)
		else $error("page erase pulse length wrong");
	chk_module_len: assert property (leave(PH_PULSE) ##0 isMod |->
		phaseCycles == lenOf(curPre, `MULT4096_MAX, cntReg[`IDX_MERASE]) - 32'h1)
		else $error("module erase pulse length wrong");
	chk_hold_len: assert property (leave(PH_HOLD) ##0 !isMod |->
		phaseCycles == lenOf(curPre, `MULT1_MAX, cntReg[`IDX_HOLD]) - 32'h1)
		else $error("strobe hold length wrong");
	chk_mhold_len: assert property (leave(PH_HOLD) ##0 isMod |->
		phaseCycles == lenOf(curPre, `MULT8_MAX, cntReg[`IDX_MHOLD]) - 32'h1)
		else $error("module strobe hold length wrong");
	chk_recovery_len: assert property (leave(PH_RCV) |->
		phaseCycles == lenOf(curPre, `MULT1_MAX, cntReg[`IDX_RCV]) - 32'h1 ##1 !busy)
		else $error("recovery length wrong");
	chk_port_release: assert property (disable iff (1'b0) !rst_n |=> portOe == 8'h0)
		else $error("port still driven in reset");
	chk_port_freeze: assert property (powerSave |=> $stable(portOut) && $stable(portOe))
		else $error("port changed in power save");
	chk_nmi_live: assert property (clkEn && nmiIn |=> nmiPending)
		else $error("interrupt request lost");
	// Span restarts at one a cycle after the toggle, so a legal half period shows one less than its length
	chk_slow_period: assert property (clkEn && slowFlip |->
		slowSpan >= 16'(SlowMinHalf - 1))
		else $error("slow clock half period too short");
	chk_strobe_order: assert property ($rose(storageStrobe) |->
		$past(state) == PH_SETUP && busy && !programPulse)
		else $error("strobe rose outside setup end");
	chk_busy_end: assert property ($fell(busy) |-> $past(state) == PH_RCV && !storageStrobe)
		else $error("busy ended outside recovery");
	chk_tick_rate: assert property (clkEn && tick |=> preCnt == 8'h0)
		else $error("prescaler did not restart after tick");
	chk_start_setup: assert property (start_req |=>
		state == PH_SETUP && busy && !storageStrobe)
		else $error("start did not enter setup");
	chk_pulse_strobe: assert property (anyPulse |-> storageStrobe && busy)
		else $error("high voltage pulse without strobe");
	chk_pulse_single: assert property (
		$onehot0({programPulse, pageErasePulse, moduleErasePulse}))
		else $error("more than one pulse line high");
	chk_cfg_locked: assert property (busy |=>
		$stable(pgmPrescale) && $stable(dataPrescale) && $stable(targetData))
		else $error("prescaler moved during an operation");
	chk_strobe_fall: assert property ($fell(storageStrobe) |->
		state == PH_RCV && busy)
		else $error("strobe fell outside hold end");
	chk_rcv_released: assert property (state == PH_RCV |->
		!storageStrobe && !anyPulse)
		else $error("strobe or pulse high in recovery");

endmodule

// File: src/flash_timing_defines.svh
`ifndef FLASH_TIMING_DEFINES_SVH
`define FLASH_TIMING_DEFINES_SVH

// Register byte offsets
`define OFS_PGM_PRESCALE  8'h00
`define OFS_DATA_PRESCALE 8'h04
`define OFS_SETUP         8'h08
`define OFS_CTRL          8'h30
`define OFS_STATUS        8'h34
`define OFS_PORT          8'h38
`define OFS_SLOWDIV       8'h3c

// Timing count registers occupy consecutive words from OFS_SETUP
`define CNT_REGS          8
`define IDX_SETUP         3'h0
`define IDX_TRAN          3'h1
`define IDX_PROG          3'h2
`define IDX_PERASE        3'h3
`define IDX_MERASE        3'h4
`define IDX_HOLD          3'h5
`define IDX_MHOLD         3'h6
`define IDX_RCV           3'h7

// Field positions
`define CTRL_OP_LSB       0
`define CTRL_OP_MSB       1
`define CTRL_TARGET_BIT   2
`define STAT_BUSY_BIT     0
`define STAT_PHASE_LSB    1
`define STAT_PHASE_MSB    3
`define STAT_NMI_BIT      4
`define PORT_DIR_LSB      8
`define PORT_DIR_MSB      15

// Reset values
`define RST_COUNT         8'hff
`define RST_SLOWDIV       16'h01f3

// Phase multipliers, stored as (multiplier - 1)
`define MULT1_MAX         12'h000
`define MULT8_MAX         12'h007
`define MULT4096_MAX      12'hfff

// Timing
`define CLK_PERIOD_NS     10
`define SLOW_MIN_PERIOD_NS 10000
`define SLOW_MIN_HALF     ((`SLOW_MIN_PERIOD_NS / `CLK_PERIOD_NS + 1) / 2)

`endif

// File: src/flash_timing_pkg.sv
package flash_timing_pkg;

	typedef enum logic [2:0] {
		PH_IDLE  = 3'b000,
		PH_SETUP = 3'b001,
		PH_TRAN  = 3'b010,
		PH_PULSE = 3'b011,
		PH_HOLD  = 3'b100,
		PH_RCV   = 3'b101
	} phase_t;

	typedef enum logic [1:0] {
		OP_NONE   = 2'b00,
		OP_PROG   = 2'b01,
		OP_PERASE = 2'b10,
		OP_MERASE = 2'b11
	} op_t;

	// Length of the running phase: prescaler, multiplier and phase count
	typedef struct packed {
		logic [7:0]  pre;
		logic [11:0] multMax;
		logic [7:0]  count;
	} phase_cfg_t;

endpackage
